// *** rtl/bhc_hall_io.sv ***
// Hall-sensor drive I/O conditioning: converter decode, protection, gates
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bhc_hall_io
	import bhc_pkg::*;
#(
	parameter int SYNC_STAGES = 3
) (
	// Clock, reset, enable
	input  wire logic              clk_in,
	input  wire logic              resetn_in,
	input  wire logic              ce_in,
	// Converter results
	input  wire logic [ADC_W-1:0]  bus_voltage_channel_in,
	input  wire logic              bus_voltage_valid_in,
	input  wire logic [ADC_W-1:0]  speed_command_channel_in,
	input  wire logic              speed_command_valid_in,
	// Pins from sensors and switches
	input  wire logic              hall_phase_a_in,
	input  wire logic              hall_phase_b_in,
	input  wire logic              hall_phase_c_in,
	input  wire logic              start_stop_switch_in,
	input  wire logic              error_reset_switch_in,
	// PWM timer outputs
	input  wire logic              pwm_out_a_high_in,
	input  wire logic              pwm_out_a_low_in,
	input  wire logic              pwm_out_b_high_in,
	input  wire logic              pwm_out_b_low_in,
	input  wire logic              pwm_out_c_high_in,
	input  wire logic              pwm_out_c_low_in,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr_in,
	input  wire logic [DATA_W-1:0] reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic      [DATA_W-1:0] reg_rdata_out,
	// Gate drive
	output logic                   gate_a_high_out,
	output logic                   gate_a_low_out,
	output logic                   gate_b_high_out,
	output logic                   gate_b_low_out,
	output logic                   gate_c_high_out,
	output logic                   gate_c_low_out,
	// Hall events
	output logic                   hall_a_edge_event_out,
	output logic                   hall_b_edge_event_out,
	output logic                   hall_c_edge_event_out,
	// Indicators, decoded values, interrupt
	output logic                   run_indicator_out,
	output logic                   error_indicator_out,
	output logic      [MV_W-1:0]   bus_voltage_mv_out,
	output logic      [SPD_W-1:0]  speed_rpm_out,
	output logic                   speed_cw_out,
	output logic                   speed_stop_out,
	output logic                   irq_out
);

	// Whole state of the block apart from the pin synchroniser registers
	typedef struct packed {
		bhc_run_e          st;
		logic              pwm_mode;
		logic [GATE_N-1:0] port_pat;
		logic [STAT_W-1:0] stat;
		logic [STAT_W-1:0] en;
		logic [DATA_W-1:0] rdata;
		logic [GATE_N-1:0] gates;
		logic [MV_W-1:0]   volt_mv;
		logic [SPD_W-1:0]  spd_mag;
		logic              spd_cw;
		logic              spd_stop;
	} bhc_main_s;

	// Reset leaves gates off, direction clockwise and a stop pending
	localparam bhc_main_s RST_VAL = '{st: BHC_IDLE, pwm_mode: 1'b0, port_pat: '0,
		stat: '0, en: '0, rdata: '0, gates: '0, volt_mv: '0, spd_mag: '0,
		spd_cw: 1'b1, spd_stop: 1'b1};

	// Scaling product width: full-scale code times full-scale mV cannot overflow
	localparam int PROD_W = ADC_W + MV_W;

	// The synchroniser is built for exactly three stages
	if (SYNC_STAGES != 3) begin : g_chk
		$error("bhc_hall_io: SYNC_STAGES must be 3");
	end

	// The largest scaled midscale distance must fit the speed word
	if (ADC_W + SPD_SCALE_SH > SPD_W) begin : g_spd_chk
		$error("bhc_hall_io: SPD_W too narrow for the speed scale");
	end

	// State, its next value and the conditioned pins
	bhc_main_s          s_r;
	bhc_main_s          s_nxt;
	bhc_pin_if          pin_bus ();

	// Pin and PWM timer vectors
	logic [PIN_N-1:0]   pins_raw;
	logic [GATE_N-1:0]  pwm_vec;

	// Sticky status update terms
	logic [STAT_W-1:0]  stat_set;
	logic [STAT_W-1:0]  stat_clr;

	// Converter decode terms
	logic [PROD_W-1:0]  volt_prod;
	logic [MV_W-1:0]    volt_scaled;
	logic [ADC_W-1:0]   spd_dist;
	logic [SPD_W-1:0]   spd_raw;
	logic [SPD_W-1:0]   spd_clamped;
	logic               spd_cw_now;

	// Run control terms
	logic               over_volt;
	logic               run_req;
	logic               stop_req;
	logic               err_reset;
	logic [PIN_N-1:0]   hall_edge;

	// Register address match, used by both read and write decode
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// Pin vector for the synchroniser
	assign pins_raw[PIN_HALL_A]  = hall_phase_a_in;
	assign pins_raw[PIN_HALL_B]  = hall_phase_b_in;
	assign pins_raw[PIN_HALL_C]  = hall_phase_c_in;
	assign pins_raw[PIN_START]   = start_stop_switch_in;
	assign pins_raw[PIN_ERR_RST] = error_reset_switch_in;

	// All pins cross into the clock domain here
	bhc_pin_sync #(
		.WIDTH     (PIN_N)
	) u_sync (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.ce_in     (ce_in),
		.pins_in   (pins_raw),
		.pin_out   (pin_bus.src)
	);

	// PWM timer lines gathered in gate order
	assign pwm_vec[GATE_AH] = pwm_out_a_high_in;
	assign pwm_vec[GATE_AL] = pwm_out_a_low_in;
	assign pwm_vec[GATE_BH] = pwm_out_b_high_in;
	assign pwm_vec[GATE_BL] = pwm_out_b_low_in;
	assign pwm_vec[GATE_CH] = pwm_out_c_high_in;
	assign pwm_vec[GATE_CL] = pwm_out_c_low_in;

	// Linear voltage scaling: code times 30000 mV over the full-scale code
	always_comb begin
		volt_prod   = PROD_W'(bus_voltage_channel_in) * PROD_W'(VOLT_FULL_MV);
		volt_scaled = MV_W'(volt_prod / PROD_W'(VOLT_FULL_CODE));
	end

	// Speed decode: direction from midscale, distance times four, clamp
	// Midscale itself is clockwise at zero speed, so it always stops
	always_comb begin
		spd_cw_now = (speed_command_channel_in >= SPD_MID_CODE);
		if (spd_cw_now) begin
			spd_dist = speed_command_channel_in - SPD_MID_CODE;
		end else begin
			spd_dist = SPD_MID_CODE - speed_command_channel_in;
		end
		spd_raw = SPD_W'({2'h0, spd_dist} << SPD_SCALE_SH);
		if (spd_raw > SPD_LIMIT) begin
			spd_clamped = SPD_LIMIT;
		end else begin
			spd_clamped = spd_raw;
		end
	end

	// Operator requests and protection level
	// Protection acts on the captured voltage, one cycle after its strobe
	always_comb begin
		over_volt = (s_r.volt_mv > VOLT_OV_MV);
		stop_req  = pin_bus.level[PIN_START] | s_r.spd_stop;
		run_req   = ~stop_req;
		err_reset = ~pin_bus.level[PIN_ERR_RST];
		hall_edge = pin_bus.rise | pin_bus.fall;
	end

	// Events feeding the sticky status, and software clears
	always_comb begin
		stat_set            = '0;
		stat_set[ST_HALL_A] = hall_edge[PIN_HALL_A];
		stat_set[ST_HALL_B] = hall_edge[PIN_HALL_B];
		stat_set[ST_HALL_C] = hall_edge[PIN_HALL_C];
		stat_set[ST_OVERV]  = over_volt && (s_r.st != BHC_FAULT);
		stat_clr            = '0;
		if (reg_wr_in && hit(reg_addr_in, REG_INT_CLR)) begin
			stat_clr = reg_wdata_in[STAT_W-1:0];
		end
	end

	// Next state: converters, run sequence, gates, register port
	always_comb begin
		s_nxt       = s_r;
		s_nxt.rdata = '0;

		// Capture converter results on their sample strobes
		if (bus_voltage_valid_in) begin
			s_nxt.volt_mv = volt_scaled;
		end
		if (speed_command_valid_in) begin
			s_nxt.spd_mag  = spd_clamped;
			s_nxt.spd_cw   = spd_cw_now;
			s_nxt.spd_stop = (spd_clamped < SPD_STOP_MIN);
		end

		// Run sequence; overvoltage always wins
		unique case (s_r.st)
			BHC_IDLE: begin
				if (over_volt) begin
					s_nxt.st = BHC_FAULT;
				end else if (run_req) begin
					s_nxt.st = BHC_RUN;
				end
			end
			BHC_RUN: begin
				if (over_volt) begin
					s_nxt.st = BHC_FAULT;
				end else if (stop_req) begin
					s_nxt.st = BHC_IDLE;
				end
			end
			BHC_FAULT: begin
				// Leaving needs the stop level, so the motor never restarts at once
				if (err_reset && pin_bus.level[PIN_START] && !over_volt) begin
					s_nxt.st = BHC_IDLE;
				end
			end
			default: begin
				s_nxt.st = BHC_FAULT;
			end
		endcase

		// Gate source: active high, only while running, off in fault
		// Gates load with the next state, so they never lag the run indicator
		if (s_nxt.st == BHC_RUN) begin
			if (s_r.pwm_mode) begin
				s_nxt.gates = pwm_vec;
			end else begin
				s_nxt.gates = s_r.port_pat;
			end
		end else begin
			s_nxt.gates = '0;
		end

		// Sticky status: a set in the clearing cycle survives
		s_nxt.stat = (s_r.stat & ~stat_clr) | stat_set;

		// Register writes
		if (reg_wr_in) begin
			if (hit(reg_addr_in, REG_CTRL)) begin
				s_nxt.pwm_mode = reg_wdata_in[CTRL_PWM_BIT];
				s_nxt.port_pat = reg_wdata_in[CTRL_PAT_LSB +: GATE_N];
			end

			if (hit(reg_addr_in, REG_INT_EN)) begin
				s_nxt.en = reg_wdata_in[STAT_W-1:0];
			end
		end

		// Register reads, data valid for one cycle; unmapped reads zero
		if (reg_rd_in) begin
			if (hit(reg_addr_in, REG_CTRL)) begin
				s_nxt.rdata[CTRL_PWM_BIT]               = s_r.pwm_mode;
				s_nxt.rdata[CTRL_PAT_LSB +: GATE_N]     = s_r.port_pat;
			end

			if (hit(reg_addr_in, REG_STATUS)) begin
				s_nxt.rdata[STAT_W-1:0] = s_r.stat;
			end

			if (hit(reg_addr_in, REG_INT_EN)) begin
				s_nxt.rdata[STAT_W-1:0] = s_r.en;
			end

			if (hit(reg_addr_in, REG_SPEED)) begin
				s_nxt.rdata[SPD_W-1:0]   = s_r.spd_mag;
				s_nxt.rdata[SPD_CW_BIT]  = s_r.spd_cw;
				s_nxt.rdata[SPD_STOP_BIT] = s_r.spd_stop;
			end

			if (hit(reg_addr_in, REG_VOLT)) begin
				s_nxt.rdata[MV_W-1:0] = s_r.volt_mv;
			end
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_r <= RST_VAL;
		end else if (ce_in) begin
			s_r <= s_nxt;
		end
	end

	// Gate pins
	// Straight from flip-flops, so no glitch reaches the bridge
	assign gate_a_high_out = s_r.gates[GATE_AH];
	assign gate_a_low_out  = s_r.gates[GATE_AL];
	assign gate_b_high_out = s_r.gates[GATE_BH];
	assign gate_b_low_out  = s_r.gates[GATE_BL];
	assign gate_c_high_out = s_r.gates[GATE_CH];
	assign gate_c_low_out  = s_r.gates[GATE_CL];

	// Hall events straight from the synchroniser registers
	assign hall_a_edge_event_out = hall_edge[PIN_HALL_A];
	assign hall_b_edge_event_out = hall_edge[PIN_HALL_B];
	assign hall_c_edge_event_out = hall_edge[PIN_HALL_C];

	// Indicators and decoded values
	assign run_indicator_out   = (s_r.st == BHC_RUN);
	assign error_indicator_out = (s_r.st == BHC_FAULT);
	assign bus_voltage_mv_out  = s_r.volt_mv;
	assign speed_rpm_out       = s_r.spd_mag;
	assign speed_cw_out        = s_r.spd_cw;
	assign speed_stop_out      = s_r.spd_stop;
	assign reg_rdata_out       = s_r.rdata;

	// Level interrupt while any enabled sticky bit is set
	assign irq_out = |(s_r.stat & s_r.en);

endmodule
`default_nettype wire

// *** rtl/bhc_pkg.sv ***
// Shared constants and types for the hall-sensor drive conditioning block
package bhc_pkg;

	// Converter code width and register port widths
	localparam int ADC_W  = 10;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam int MV_W   = 15;
	localparam int SPD_W  = 12;
	localparam int STAT_W = 4;

	// Bus-voltage scaling: full-scale code maps to full-scale millivolts
	localparam logic [ADC_W-1:0] VOLT_FULL_CODE = 10'h3FF;
	localparam logic [MV_W-1:0]  VOLT_FULL_MV   = 15'h7530;	// 30000 mV
	localparam logic [MV_W-1:0]  VOLT_OV_MV     = 15'h6D60;	// 28000 mV

	// Speed command decode: midscale split, 512 codes span 2048 rpm
	localparam logic [ADC_W-1:0] SPD_MID_CODE = 10'h1FF;
	localparam int               SPD_SCALE_SH = 2;
	localparam logic [SPD_W-1:0] SPD_LIMIT    = 12'h7D0;	// 2000 rpm
	localparam logic [SPD_W-1:0] SPD_STOP_MIN = 12'h226;	// 550 rpm

	// Synchronised pin positions
	localparam int PIN_N       = 5;
	localparam int PIN_HALL_A  = 0;
	localparam int PIN_HALL_B  = 1;
	localparam int PIN_HALL_C  = 2;
	localparam int PIN_START   = 3;
	localparam int PIN_ERR_RST = 4;
	localparam logic [PIN_N-1:0] PIN_RST_LVL = 5'h18;	// Switches idle high

	// Gate vector positions
	localparam int GATE_N  = 6;
	localparam int GATE_AH = 5;
	localparam int GATE_AL = 4;
	localparam int GATE_BH = 3;
	localparam int GATE_BL = 2;
	localparam int GATE_CH = 1;
	localparam int GATE_CL = 0;

	// Register offsets (word index)
	localparam logic [ADDR_W-1:0] REG_CTRL    = 3'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 3'h1;
	localparam logic [ADDR_W-1:0] REG_INT_CLR = 3'h2;
	localparam logic [ADDR_W-1:0] REG_INT_EN  = 3'h3;
	localparam logic [ADDR_W-1:0] REG_SPEED   = 3'h4;
	localparam logic [ADDR_W-1:0] REG_VOLT    = 3'h5;

	// Control register fields
	localparam int CTRL_PWM_BIT = 0;
	localparam int CTRL_PAT_LSB = 1;

	// Speed register fields
	localparam int SPD_CW_BIT   = 12;
	localparam int SPD_STOP_BIT = 13;

	// Status bits
	localparam int ST_HALL_A = 0;
	localparam int ST_HALL_B = 1;
	localparam int ST_HALL_C = 2;
	localparam int ST_OVERV  = 3;

	// Run sequence states, Gray coded along idle-run-fault
	typedef enum logic [1:0] {
		BHC_IDLE  = 2'h0,
		BHC_RUN   = 2'h1,
		BHC_FAULT = 2'h3
	} bhc_run_e;

endpackage

// *** rtl/bhc_pin_if.sv ***
// Interface carrying conditioned pin levels and edge pulses
`timescale 1ns/1ps
`default_nettype none
interface bhc_pin_if;
	import bhc_pkg::*;
	logic [PIN_N-1:0] level;
	logic [PIN_N-1:0] rise;
	logic [PIN_N-1:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// *** rtl/bhc_pin_sync.sv ***
// Three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module bhc_pin_sync
	import bhc_pkg::*;
#(
	parameter int WIDTH = PIN_N
) (
	// Clock, reset, enable
	input  wire logic             clk_in,
	input  wire logic             resetn_in,
	input  wire logic             ce_in,
	// Raw pins
	input  wire logic [WIDTH-1:0] pins_in,
	// Conditioned output
	bhc_pin_if.src                pin_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
		logic [WIDTH-1:0] rise;
		logic [WIDTH-1:0] fall;
	} bhc_sync_s;

	localparam bhc_sync_s RST_VAL = '{s1: PIN_RST_LVL, s2: PIN_RST_LVL, s3: PIN_RST_LVL,
		level: PIN_RST_LVL, rise: '0, fall: '0};

	bhc_sync_s s_r;
	bhc_sync_s s_nxt;

	// Width must match the conditioned vector
	if (WIDTH != PIN_N) begin : g_chk
		$error("bhc_pin_sync: WIDTH must equal PIN_N");
	end

	// Level accepted once stages two and three agree; edges pulse one cycle
	always_comb begin
		s_nxt       = s_r;
		s_nxt.s1    = pins_in;
		s_nxt.s2    = s_r.s1;
		s_nxt.s3    = s_r.s2;
		s_nxt.level = (s_r.s2 & s_r.s3) | (s_r.level & (s_r.s2 | s_r.s3));
		s_nxt.rise  = s_nxt.level & ~s_r.level;
		s_nxt.fall  = ~s_nxt.level & s_r.level;
	end

	// State register
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_r <= RST_VAL;
		end else if (ce_in) begin
			s_r <= s_nxt;
		end
	end

	// Outputs
	assign pin_out.level = s_r.level;
	assign pin_out.rise  = s_r.rise;
	assign pin_out.fall  = s_r.fall;

endmodule
`default_nettype wire

// *** verification/bhc_hall_io_checker.sv ***
// Port-level assertions for the hall drive conditioning block
`timescale 1ns/1ps
`default_nettype none
module bhc_hall_io_checker
	import bhc_pkg::*;
(
	// Clock, reset and watched inputs
	input wire logic              clk_in,
	input wire logic              resetn_in,
	input wire logic              ce_in,
	input wire logic              speed_command_valid_in,
	input wire logic [ADC_W-1:0]  speed_command_channel_in,
	input wire logic              start_stop_switch_in,
	input wire logic              reg_rd_in,
	// Watched outputs
	input wire logic              gate_a_high_out,
	input wire logic              gate_a_low_out,
	input wire logic              gate_b_high_out,
	input wire logic              gate_b_low_out,
	input wire logic              gate_c_high_out,
	input wire logic              gate_c_low_out,
	input wire logic              hall_a_edge_event_out,
	input wire logic              run_indicator_out,
	input wire logic              error_indicator_out,
	input wire logic [MV_W-1:0]   bus_voltage_mv_out,
	input wire logic [SPD_W-1:0]  speed_rpm_out,
	input wire logic              speed_cw_out,
	input wire logic              speed_stop_out,
	input wire logic [DATA_W-1:0] reg_rdata_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// Gate vector, upper then lower per phase
	wire logic [5:0] gate_w = {gate_a_high_out, gate_a_low_out, gate_b_high_out,
		gate_b_low_out, gate_c_high_out, gate_c_low_out};
	// Speed code taken at an enabled edge
	sequence seq_spd_take;
		ce_in && speed_command_valid_in;
	endsequence
	// Overvoltage seen at an enabled edge
	sequence seq_over;
		ce_in && (bus_voltage_mv_out > VOLT_OV_MV);
	endsequence
	// Stop level held long enough to cross the synchroniser
	sequence seq_stop_held;
		(ce_in && start_stop_switch_in)[*6];
	endsequence
	AST_SPD_CW: assert property (
		seq_spd_take ##0 (speed_command_channel_in >= SPD_MID_CODE) |=> speed_cw_out)
		else $error("upper speed code not clockwise");
	AST_SPD_CCW: assert property (
		seq_spd_take ##0 (speed_command_channel_in < SPD_MID_CODE) |=> !speed_cw_out)
		else $error("lower speed code not counter-clockwise");
	AST_SPD_LIMIT: assert property (speed_rpm_out <= SPD_LIMIT)
		else $error("speed magnitude above limit");
	AST_SPD_STOP: assert property (
		speed_stop_out == (speed_rpm_out < SPD_STOP_MIN))
		else $error("stop flag disagrees with magnitude");
	AST_VOLT_MAX: assert property (bus_voltage_mv_out <= VOLT_FULL_MV)
		else $error("scaled voltage above full scale");
	AST_OVER_TRIP: assert property (
		seq_over |=> error_indicator_out && gate_w == 6'h00)
		else $error("overvoltage did not trip");
	AST_ERR_OFF: assert property (
		error_indicator_out |-> gate_w == 6'h00 && !run_indicator_out)
		else $error("gates or run active while in error");
	AST_STOP_PIN: assert property (seq_stop_held |=> !run_indicator_out)
		else $error("running with stop level held");
	AST_HALL_PULSE: assert property (
		hall_a_edge_event_out |=> !hall_a_edge_event_out)
		else $error("hall event longer than one cycle");
	AST_RD_IDLE: assert property (ce_in && !reg_rd_in |=> reg_rdata_out == 16'h0000)
		else $error("read data without read");
endmodule
`default_nettype wire

// *** verification/bhc_motor_model.sv ***
// Behavioural hall sensors and operator switches on the motor side
`timescale 1ns/1ps
`default_nettype none
module bhc_motor_model (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	// Commands from the bench
	input  wire logic       spin_in,
	input  wire logic [3:0] step_gap_in,
	input  wire logic       run_req_in,
	input  wire logic       clr_req_in,
	// Sensor and switch pins
	output logic            hall_a_out,
	output logic            hall_b_out,
	output logic            hall_c_out,
	output logic            start_stop_out,
	output logic            error_reset_out
);
	localparam logic [17:0] HALL_SEQ = 18'b101_100_110_010_011_001;
	logic [2:0] step_r;
	logic [3:0] gap_r;
	// Rotor advances one of six positions after each gap
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			step_r <= 3'h0;
			gap_r  <= 4'h0;
		end else if (spin_in && gap_r >= step_gap_in) begin
			step_r <= (step_r == 3'h5) ? 3'h0 : step_r + 3'h1;
			gap_r  <= 4'h0;
		end else if (spin_in) begin
			gap_r <= gap_r + 4'h1;
		end
	end
	// One hall changes per position; switches are active low levels
	assign {hall_c_out, hall_b_out, hall_a_out} = HALL_SEQ[step_r * 3 +: 3];
	assign start_stop_out  = !run_req_in;
	assign error_reset_out = !clr_req_in;
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the hall drive conditioning block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import bhc_pkg::*;
	`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
		$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
	localparam logic [9:0] CODES [8] = '{10'h000, 10'h1FE, 10'h1FF, 10'h200,
		10'h175, 10'h288, 10'h289, 10'h3FF};
	logic              clk_in = 1'b0;
	logic              resetn_in = 1'b0;
	logic [ADC_W-1:0]  bus_voltage_channel_in = '0;
	logic [ADC_W-1:0]  speed_command_channel_in = '0;
	logic              bus_voltage_valid_in = 1'b0;
	logic              speed_command_valid_in = 1'b0;
	logic              hall_phase_a_in, hall_phase_b_in, hall_phase_c_in;
	logic              start_stop_switch_in, error_reset_switch_in;
	logic [ADDR_W-1:0] reg_addr_in = '0;
	logic [DATA_W-1:0] reg_wdata_in = '0;
	logic              reg_wr_in = 1'b0;
	logic              reg_rd_in = 1'b0;
	logic [DATA_W-1:0] reg_rdata_out, e, q_top;
	logic              gate_a_high_out, gate_a_low_out, gate_b_high_out;
	logic              gate_b_low_out, gate_c_high_out, gate_c_low_out;
	logic              hall_a_edge_event_out, hall_b_edge_event_out, hall_c_edge_event_out;
	logic              run_indicator_out, error_indicator_out, irq_out;
	logic              speed_cw_out, speed_stop_out, rd_d = 1'b0;
	logic [MV_W-1:0]   bus_voltage_mv_out, mv;
	logic [SPD_W-1:0]  speed_rpm_out;
	logic [5:0]        pwm_r = '0;
	logic              spin = 1'b0, run_req = 1'b0, clr_req = 1'b0, ce = 1'b1;
	logic [3:0]        gap = 4'h4;
	logic [9:0]        s, v;
	logic [2:0]        hp;
	logic [31:0]       seed = 32'h24d4_088c;
	logic [DATA_W-1:0] exp_q [$];
	int                fail_count = 0, compares = 0;
	int                ev [3], pc [3], ev0 [3], pc0 [3];
	wire  [5:0]        gates = {gate_a_high_out, gate_a_low_out, gate_b_high_out,
		gate_b_low_out, gate_c_high_out, gate_c_low_out};
	wire  [2:0]        hall_w = {hall_phase_c_in, hall_phase_b_in, hall_phase_a_in};
	wire  [2:0]        evt_w = {hall_c_edge_event_out, hall_b_edge_event_out,
		hall_a_edge_event_out};
	bhc_hall_io dut (.clk_in, .resetn_in, .ce_in(ce), .bus_voltage_channel_in,
		.bus_voltage_valid_in, .speed_command_channel_in, .speed_command_valid_in,
		.hall_phase_a_in, .hall_phase_b_in, .hall_phase_c_in, .start_stop_switch_in,
		.error_reset_switch_in, .pwm_out_a_high_in(pwm_r[5]), .pwm_out_a_low_in(pwm_r[4]),
		.pwm_out_b_high_in(pwm_r[3]), .pwm_out_b_low_in(pwm_r[2]),
		.pwm_out_c_high_in(pwm_r[1]), .pwm_out_c_low_in(pwm_r[0]), .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .gate_a_high_out,
		.gate_a_low_out, .gate_b_high_out, .gate_b_low_out, .gate_c_high_out,
		.gate_c_low_out, .hall_a_edge_event_out, .hall_b_edge_event_out,
		.hall_c_edge_event_out, .run_indicator_out, .error_indicator_out,
		.bus_voltage_mv_out, .speed_rpm_out, .speed_cw_out, .speed_stop_out, .irq_out);
	bhc_motor_model u_motor (.clk_in, .resetn_in, .spin_in(spin), .step_gap_in(gap),
		.run_req_in(run_req), .clr_req_in(clr_req), .hall_a_out(hall_phase_a_in),
		.hall_b_out(hall_phase_b_in), .hall_c_out(hall_phase_c_in),
		.start_stop_out(start_stop_switch_in), .error_reset_out(error_reset_switch_in));
	// 10 MHz clock
	initial begin
		forever #50 clk_in = ~clk_in;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Speed word: stop, direction, clamped magnitude
	function automatic logic [15:0] spd_exp(input logic [9:0] c);
		logic [11:0] m;
		m = (c >= 10'h1FF) ? 12'(c - 10'h1FF) << 2 : 12'(10'h1FF - c) << 2;
		if (m > 12'd2000) m = 12'd2000;
		return {2'b00, m < 12'd550, c >= 10'h1FF, m};
	endfunction
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		exp_q.push_back(x);
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
	endtask
	task automatic conv(input logic [9:0] sc, input logic [9:0] vc);
		@(posedge clk_in);
		speed_command_channel_in <= sc;
		bus_voltage_channel_in   <= vc;
		speed_command_valid_in   <= 1'b1;
		bus_voltage_valid_in     <= 1'b1;
		@(posedge clk_in);
		speed_command_valid_in <= 1'b0;
		bus_voltage_valid_in   <= 1'b0;
		wait_n(1);
	endtask
	task automatic pins(input logic r, input logic c);
		@(posedge clk_in);
		run_req <= r;
		clr_req <= c;
		wait_n(8);
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Read data checked in the cycle after each read strobe
	always @(posedge clk_in) rd_d <= reg_rd_in;
	always @(negedge clk_in) begin
		if (rd_d) begin
			q_top = exp_q.pop_front();
			`CHK(reg_rdata_out, q_top)
		end
	end
	// Hall pin changes and edge events per phase
	always @(posedge clk_in) begin
		hp <= hall_w;
		for (int k = 0; k < 3; k++) begin
			ev[k] <= ev[k] + int'(evt_w[k]);
			pc[k] <= pc[k] + int'(hp[k] ^ hall_w[k]);
		end
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		results();
	end
	initial begin
		repeat (16) @(posedge clk_in);
		resetn_in <= 1'b1;
		`CHK({gates, run_indicator_out, error_indicator_out, irq_out}, 9'h000)
		`CHK({speed_cw_out, speed_stop_out}, 2'b11)
		wr(3'h6, 16'hFFFF);
		wr(REG_SPEED, 16'hFFFF);
		rd(REG_SPEED, 16'h3000);
		for (int a = 6; a < 8; a++) rd(3'(a), 16'h0000);
		rd(REG_INT_CLR, 16'h0000);
		rd(REG_CTRL, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			s = (i < 8) ? CODES[i] : 10'(rnd());
			v = (i < 2) ? 10'(i * 954) : 10'(rnd() % 955);
			e = spd_exp(s);
			mv = 15'((32'(v) * 32'd30000) / 32'd1023);
			conv(s, v);
			`CHK({speed_stop_out, speed_cw_out, speed_rpm_out}, e[13:0])
			`CHK(bus_voltage_mv_out, mv)
			rd(REG_SPEED, e);
			rd(REG_VOLT, {1'b0, mv});
		end
		// Clock enable low: a converter strobe must leave the captured values alone
		@(posedge clk_in);
		ce <= 1'b0;
		conv(10'h000, 10'h3FF);
		`CHK({speed_rpm_out, bus_voltage_mv_out}, {e[11:0], mv})
		@(posedge clk_in);
		ce <= 1'b1;
		$display("test converter decode done");
		ev0 = ev;
		pc0 = pc;
		@(posedge clk_in);
		spin <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			gap <= 4'(4 + rnd() % 12);
			repeat (40) @(posedge clk_in);
		end
		spin <= 1'b0;
		wait_n(10);
		for (int k = 0; k < 3; k++) `CHK(ev[k] - ev0[k], pc[k] - pc0[k])
		rd(REG_STATUS, 16'h0007);
		`CHK(irq_out, 1'b0)
		wr(REG_INT_EN, 16'h0007);
		wait_n(2);
		`CHK(irq_out, 1'b1)
		wr(REG_INT_CLR, 16'h0007);
		wait_n(2);
		`CHK(irq_out, 1'b0)
		rd(REG_STATUS, 16'h0000);
		$display("test hall events done");
		conv(10'h1FF, 10'h000);
		pins(1'b1, 1'b0);
		`CHK(run_indicator_out, 1'b0)
		wr(REG_CTRL, 16'h0048);
		conv(10'h3FF, 10'h000);
		wait_n(3);
		`CHK({run_indicator_out, gates}, 7'h64)
		wr(REG_CTRL, 16'h0001);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_in);
			pwm_r <= 6'(rnd());
			wait_n(2);
			`CHK(gates, pwm_r)
		end
		pins(1'b0, 1'b0);
		`CHK(run_indicator_out, 1'b0)
		pins(1'b1, 1'b0);
		`CHK(run_indicator_out, 1'b1)
		conv(10'h3FF, 10'h3FF);
		wait_n(2);
		`CHK({error_indicator_out, run_indicator_out, gates}, 8'h80)
		rd(REG_VOLT, 16'h7530);
		rd(REG_STATUS, 16'h0008);
		conv(10'h3FF, 10'h000);
		pins(1'b1, 1'b1);
		`CHK(error_indicator_out, 1'b1)
		pins(1'b0, 1'b1);
		`CHK({error_indicator_out, run_indicator_out}, 2'b00)
		pins(1'b0, 1'b0);
		$display("test run and protection done");
		results();
	end
endmodule
bind bhc_hall_io bhc_hall_io_checker u_chk (.clk_in, .resetn_in, .ce_in,
	.speed_command_valid_in, .speed_command_channel_in, .start_stop_switch_in, .reg_rd_in,
	.gate_a_high_out, .gate_a_low_out, .gate_b_high_out, .gate_b_low_out, .gate_c_high_out,
	.gate_c_low_out, .hall_a_edge_event_out, .run_indicator_out, .error_indicator_out,
	.bus_voltage_mv_out, .speed_rpm_out, .speed_cw_out, .speed_stop_out, .reg_rdata_out);
`default_nettype wire
